//--- common/wdr_defines.svh
// register offsets, field positions and timing constants of the watchdog block
`ifndef WDR_DEFINES_SVH
`define WDR_DEFINES_SVH
`define WDR_ADDR_W 8
`define WDR_OFF_WDCTL 8'h60
`define WDR_OFF_CAUSE 8'h61
`define WDR_BIT_IRQ_FLAG 7
`define WDR_BIT_IRQ_EN 6
`define WDR_BIT_PRE3 5
`define WDR_BIT_CHG_EN 4
`define WDR_BIT_RST_EN 3
`define WDR_BIT_WDOG_FLAG 3
`define WDR_BIT_BOR_FLAG 2
`define WDR_BIT_EXT_FLAG 1
`define WDR_BIT_POR_FLAG 0
`define WDR_CAUSE_MASK 8'h0F
`define WDR_CHG_WINDOW 3'h4
`define WDR_PRE_MAX 4'h9
`define WDR_BASE_CYCLES 21'h000800
`define WDR_CORE_MHZ 100
`define WDR_WOSC_KHZ 128
`endif

//--- common/wdr_pkg.sv
// types shared by the watchdog block
package wdr_pkg;
	typedef enum logic [1:0]
	{
		WDR_STOPPED = 2'b00,
		WDR_IRQ = 2'b01,
		WDR_RESET = 2'b10,
		WDR_IRQ_RESET = 2'b11
	} wdr_mode_type;
	typedef struct packed
	{
		logic [20:0] count;
		logic [3:0] period_sel;
	} wdr_cnt_state_type;
	typedef struct packed
	{
		logic irq_flag;
		logic irq_en;
		logic chg_en;
		logic [2:0] chg_cnt;
		logic rst_en;
		logic [3:0] prescale;
		logic wdog_flag;
		logic bor_flag;
		logic ext_flag;
		logic por_flag;
		logic [7:0] rdata;
		logic sys_rst;
		logic irq_req;
	} wdr_state_type;
endpackage

//--- core/wdr_counter.sv
// watchdog oscillator cycle counter with prescale compare
`timescale 1ns/100ps
`include "wdr_defines.svh"
module wdr_counter
	import wdr_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic rst, // synchronous reset
	input wire logic osc_tick, // one watchdog oscillator cycle
	input wire logic restart, // restart instruction
	input wire logic run, // watchdog not stopped
	input wire logic [3:0] prescale, // selected period code
	output logic timeout // one-cycle timeout pulse
);
	wdr_cnt_state_type s_r, s_nxt;
	logic [20:0] limit;
	always_comb
	begin
		// reserved codes clamp to the longest period
		if (prescale > `WDR_PRE_MAX)
			limit = `WDR_BASE_CYCLES << `WDR_PRE_MAX;
		else
			limit = `WDR_BASE_CYCLES << prescale;
		s_nxt = s_r;
		timeout = 1'b0;
		s_nxt.period_sel = prescale;
		if (restart || !run || (prescale != s_r.period_sel))
			s_nxt.count = 21'h000000;
		else if (osc_tick)
		begin
			if (s_r.count + 21'h000001 >= limit)
			begin
				timeout = 1'b1;
				s_nxt.count = 21'h000000;
			end
			else
				s_nxt.count = s_r.count + 21'h000001;
		end
	end
	always_ff @(posedge core_clk)
	begin
		if (rst)
			s_r <= '{count: 21'h000000, period_sel: 4'h0};
		else
			s_r <= s_nxt;
	end
endmodule

//--- core/wdr_watchdog.sv
// watchdog timer with reset-cause flags and register port
// What this block does
// - reset-cause upper four bits always read as zero
// - watchdog reset sets bit 3; power-on or written zero clears it
// - brown-out reset sets bit 2; power-on or written zero clears it
// - external reset sets bit 1; power-on or written zero clears it
// - power-on sets bit 0; only a written zero clears it
// - timeout in interrupt mode sets flag bit 7; vector or written one clears
// - interrupt requested only with global enable, irq enable and flag set
// - fuse and enables select stopped, interrupt, reset or combined mode
// - in combined mode vector clears irq enable and flag
// - combined mode: unserviced flag at next timeout causes system reset
// - clearing reset enable or changing prescale needs change enable; it self-clears after four
// - reset enable forced to one while watchdog reset flag set
// - prescale code 0..9 gives 2048 doubling to 1048576 cycles; rest reserved
// - after a watchdog reset the watchdog stays enabled in reset or combined mode
// - counts watchdog oscillator cycles; restart returns counter to zero
// - programmed fuse holds reset enable one and irq enable zero
// - reset-mode timeout gives a one core cycle reset pulse
`timescale 1ns/100ps
`include "wdr_defines.svh"
module wdr_watchdog
	import wdr_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [7:0] reg_rdata, // read data, cycle after strobe
	input wire logic osc_tick, // one-cycle pulse per watchdog oscillator cycle
	input wire logic wdr_restart, // restart instruction pulse
	input wire logic always_on_fuse, // 0 = programmed
	input wire logic global_irq_en, // global interrupt enable of core status
	input wire logic irq_ack, // watchdog vector executed
	input wire logic poweron_event, // power-on reset event
	input wire logic external_event, // external pin reset event
	input wire logic brownout_event, // brown-out reset event
	output logic sys_reset, // one-cycle system reset pulse
	output logic irq_req // interrupt request level
);
	wdr_state_type s_r, s_nxt;
	wdr_mode_type mode;
	logic timeout;
	logic fuse_on;
	logic wr_ctl, wr_cause;
	logic [7:0] d;
	logic new_rst_en;
	logic [3:0] new_pre;

	assign fuse_on = !always_on_fuse;
	assign wr_ctl = reg_wr && (reg_addr == `WDR_OFF_WDCTL);
	assign wr_cause = reg_wr && (reg_addr == `WDR_OFF_CAUSE);
	assign d = reg_wdata;

	always_comb
	begin
		if (fuse_on)
			mode = WDR_RESET;
		else
			mode = wdr_mode_type'({s_r.rst_en, s_r.irq_en});
	end

	wdr_counter u_counter
	(
		.core_clk(core_clk),
		.rst(rst),
		.osc_tick(osc_tick),
		.restart(wdr_restart),
		.run(mode != WDR_STOPPED),
		.prescale(s_r.prescale),
		.timeout(timeout)
	);

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sys_rst = 1'b0;
		new_rst_en = s_r.rst_en;
		new_pre = s_r.prescale;
		// change window: chg_cnt counts up, closing after four cycles
		if (s_r.chg_en)
		begin
			if (s_r.chg_cnt == `WDR_CHG_WINDOW - 3'h1)
				s_nxt.chg_en = 1'b0;
			s_nxt.chg_cnt = s_r.chg_cnt + 3'h1;
		end
		if (wr_ctl)
		begin
			s_nxt.irq_en = d[`WDR_BIT_IRQ_EN];
			if (d[`WDR_BIT_IRQ_FLAG])
				s_nxt.irq_flag = 1'b0;
			// setting reset enable is always allowed
			if (d[`WDR_BIT_RST_EN])
				new_rst_en = 1'b1;
			else if (s_r.chg_en)
				new_rst_en = 1'b0;
			if (s_r.chg_en)
				new_pre = {d[`WDR_BIT_PRE3], d[2:0]};
			if (d[`WDR_BIT_CHG_EN] && d[`WDR_BIT_RST_EN])
			begin
				s_nxt.chg_en = 1'b1;
				s_nxt.chg_cnt = 3'h0;
			end
			else if (s_r.chg_en)
				s_nxt.chg_en = 1'b0;
		end
		s_nxt.rst_en = new_rst_en;
		s_nxt.prescale = new_pre;
		if (wr_cause)
		begin
			if (!d[`WDR_BIT_WDOG_FLAG])
				s_nxt.wdog_flag = 1'b0;
			if (!d[`WDR_BIT_BOR_FLAG])
				s_nxt.bor_flag = 1'b0;
			if (!d[`WDR_BIT_EXT_FLAG])
				s_nxt.ext_flag = 1'b0;
			if (!d[`WDR_BIT_POR_FLAG])
				s_nxt.por_flag = 1'b0;
		end
		if (irq_ack && s_r.irq_req)
		begin
			s_nxt.irq_flag = 1'b0;
			if (mode == WDR_IRQ_RESET)
				s_nxt.irq_en = 1'b0;
		end
		if (timeout)
		begin
			unique case (mode)
				WDR_STOPPED:
					;
				WDR_IRQ:
					s_nxt.irq_flag = 1'b1;
				WDR_RESET:
					s_nxt.sys_rst = 1'b1;
				WDR_IRQ_RESET:
					if (s_r.irq_flag)
						s_nxt.sys_rst = 1'b1;
					else
						s_nxt.irq_flag = 1'b1;
			endcase
		end
		// hardware sets win over software clears
		if (s_nxt.sys_rst)
			s_nxt.wdog_flag = 1'b1;
		if (brownout_event)
			s_nxt.bor_flag = 1'b1;
		if (external_event)
			s_nxt.ext_flag = 1'b1;
		if (s_nxt.wdog_flag)
			s_nxt.rst_en = 1'b1;
		if (fuse_on)
		begin
			s_nxt.rst_en = 1'b1;
			s_nxt.irq_en = 1'b0;
		end
		s_nxt.irq_req = s_nxt.irq_flag && s_nxt.irq_en && global_irq_en;
		// read data for the following cycle
		s_nxt.rdata = 8'h00;
		if (reg_rd && reg_addr == `WDR_OFF_WDCTL)
			s_nxt.rdata = {s_r.irq_flag, s_r.irq_en, s_r.prescale[3], s_r.chg_en, s_r.rst_en, s_r.prescale[2:0]};
		else if (reg_rd && reg_addr == `WDR_OFF_CAUSE)
			s_nxt.rdata = {4'h0, s_r.wdog_flag, s_r.bor_flag, s_r.ext_flag, s_r.por_flag} & `WDR_CAUSE_MASK;
		// power-on clears the other causes and marks itself
		if (poweron_event)
		begin
			s_nxt.wdog_flag = 1'b0;
			s_nxt.bor_flag = 1'b0;
			s_nxt.ext_flag = 1'b0;
			s_nxt.por_flag = 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_r.irq_flag <= 1'b0;
			s_r.irq_en <= 1'b0;
			s_r.chg_en <= 1'b0;
			s_r.chg_cnt <= 3'h0;
			s_r.rst_en <= 1'b0;
			s_r.prescale <= 4'h0;
			s_r.rdata <= 8'h00;
			s_r.sys_rst <= 1'b0;
			s_r.irq_req <= 1'b0;
			// cause flags survive the block reset; only events and software move them
			s_r.wdog_flag <= s_nxt.wdog_flag;
			s_r.bor_flag <= s_nxt.bor_flag;
			s_r.ext_flag <= s_nxt.ext_flag;
			s_r.por_flag <= s_nxt.por_flag;
		end
		else
			s_r <= s_nxt;
	end

	assign reg_rdata = s_r.rdata;
	assign sys_reset = s_r.sys_rst;
	assign irq_req = s_r.irq_req;
endmodule

//--- tb/wdr_watchdog_assertions.sv
// port-level assertions for the watchdog block
`timescale 1ns/100ps
module wdr_watchdog_assertions
(
	input wire logic core_clk, // clock
	input wire logic rst, // reset
	input wire logic [7:0] reg_addr, // address
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_rdata, // read data
	input wire logic wdr_restart, // restart
	input wire logic always_on_fuse, // fuse
	input wire logic global_irq_en, // global enable
	input wire logic irq_ack, // vector taken
	input wire logic poweron_event, // power-on
	input wire logic sys_reset, // reset pulse
	input wire logic irq_req // interrupt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_cause_rd;
		reg_rd && reg_addr == 8'h61;
	endsequence
	sequence s_wdog_then_rd;
		sys_reset ##1 (reg_rd && reg_addr == 8'h61 && !poweron_event);
	endsequence
	a_cause_upper_zero: assert property (s_cause_rd |=> reg_rdata[7:4] == 4'h0)
		else $error("cause upper bits not zero");
	a_wdog_flag_set: assert property (s_wdog_then_rd |=> reg_rdata[3])
		else $error("watchdog flag missing after reset");
	a_pulse_one_cycle: assert property ($rose(sys_reset) |=> $fell(sys_reset))
		else $error("reset pulse too long");
	a_pulse_gap: assert property (sys_reset |=> !sys_reset [*8])
		else $error("reset pulses too close");
	a_irq_needs_global: assert property (!global_irq_en |=> !irq_req)
		else $error("irq without global enable");
	a_fuse_no_irq: assert property (!always_on_fuse [*3] |-> !irq_req)
		else $error("irq with fuse programmed");
	a_ack_clears_irq: assert property (irq_req && irq_ack |-> ##2 !irq_req)
		else $error("irq not cleared by vector");
	a_restart_holds: assert property (wdr_restart |-> ##2 !sys_reset [*8])
		else $error("reset right after restart");
endmodule

//--- tb/wdr_watchdog_tb.sv
// self-checking bench for the watchdog block
`timescale 1ns/100ps
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin errors++; \
	$display("unexpected at %0t: got %h want %h", $time, g, w); end end
module wdr_watchdog_tb import wdr_pkg::*;;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic osc_tick = 1'b0;
	logic wdr_restart = 1'b0;
	logic always_on_fuse = 1'b1;
	logic global_irq_en = 1'b1;
	logic irq_ack = 1'b0;
	logic poweron_event = 1'b1;
	logic external_event = 1'b0;
	logic brownout_event = 1'b0;
	logic sys_reset;
	logic irq_req;
	logic [7:0] lfsr = 8'h31;
	logic rd_q = 1'b0;
	logic [7:0] exp_q[$];
	int errors = 0;
	int samples_checked = 0;
	int tick_cnt = 0;
	int t0 = 0;
	wdr_watchdog u_wdr_watchdog (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .osc_tick,
		.wdr_restart, .always_on_fuse, .global_irq_en, .irq_ack, .poweron_event, .external_event, .brownout_event,
		.sys_reset, .irq_req);
	initial
	begin
		forever #5 core_clk = ~core_clk;
	end
	function automatic logic [7:0] lfsr_next(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// random oscillator ticks; read data checked in the cycle after the strobe
	always @(posedge core_clk)
	begin
		lfsr <= lfsr_next(lfsr);
		osc_tick <= lfsr[0];
		tick_cnt <= tick_cnt + int'(osc_tick);
		rd_q <= reg_rd;
		if (rd_q)
		begin
			logic [7:0] exp_r;
			exp_r = exp_q.pop_front();
			`CHK(reg_rdata, exp_r)
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask
	// one-cycle pulses: ack, restart, external, brown-out
	task automatic ev(input logic [3:0] m);
		@(posedge core_clk);
		{irq_ack, wdr_restart, external_event, brownout_event} <= m;
		@(posedge core_clk);
		{irq_ack, wdr_restart, external_event, brownout_event} <= 4'h0;
	endtask
	task automatic wait_hi(input bit on_rst);
		for (int i = 0; i < 20000; i++)
		begin
			@(posedge core_clk);
			#1;
			if (on_rst ? sys_reset : irq_req)
				return;
		end
		errors++;
		$display("unexpected at %0t: wait ran out", $time);
		wrap_up();
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		poweron_event <= 1'b0;
		rd(8'h61, 8'h01);
		rd(8'h60, 8'h00);
		ev(4'h3);
		rd(8'h61, 8'h07);
		wr(8'h61, 8'h00);
		rd(8'h61, 8'h00);
		wr(8'h60, 8'h40);
		// every oscillator tick from the edge after the enabling write counts
		#1 t0 = tick_cnt;
		wait_hi(1'b0);
		`CHK(tick_cnt - t0, 2048)
		rd(8'h60, 8'hC0);
		wr(8'h60, 8'hC0);
		rd(8'h60, 8'h40);
		`CHK(irq_req, 1'b0)
		wr(8'h60, 8'h48);
		wait_hi(1'b0);
		ev(4'h8);
		rd(8'h60, 8'h08);
		wr(8'h60, 8'h48);
		rd(8'h60, 8'h48);
		// first timeout only flags; the unserviced second one resets
		wait_hi(1'b1);
		rd(8'h61, 8'h08);
		ev(4'h4);
		wr(8'h60, 8'h98);
		wr(8'h60, 8'h00);
		rd(8'h60, 8'h08);
		wr(8'h61, 8'h00);
		wr(8'h60, 8'h00);
		rd(8'h60, 8'h08);
		wr(8'h60, 8'h18);
		rd(8'h60, 8'h18);
		wr(8'h60, 8'h21);
		rd(8'h60, 8'h21);
		wr(8'h60, 8'h39);
		repeat (6) @(posedge core_clk);
		wr(8'h60, 8'h00);
		rd(8'h60, 8'h29);
		always_on_fuse <= 1'b0;
		global_irq_en <= 1'b0;
		wr(8'h60, 8'h40);
		rd(8'h60, 8'h29);
		repeat (4) @(posedge core_clk);
		`CHK(exp_q.size(), 0)
		wrap_up();
	end
endmodule
bind wdr_watchdog wdr_watchdog_assertions u_wdr_watchdog_assertions (.core_clk, .rst, .reg_addr, .reg_rd,
	.reg_rdata, .wdr_restart, .always_on_fuse, .global_irq_en, .irq_ack, .poweron_event, .sys_reset, .irq_req);
